//--- hdl/tcf_timer.sv
// timer counter with run, soft reset, reload and direction control
//
// The address map and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/1ps
//
// Function
// - clearing run halts divider and counter, count value kept
// - soft reset bit write-only, reinitialises block, clears after one cycle
// - reload mode: at terminal reload from preload, continue, edge event
// - done mode: at terminal stop in done state, level interrupt held
// - counting up saturates at all ones and raises terminal event
// - counting down saturates at zero, its terminal condition
// - setting run restarts divider, starts counter, clears pending events
// - block enable resets to zero and gates the divider and counter

module tcf_timer #(
   parameter int CNT_W = 32,
   parameter int PRE_W = 16
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic irq
);

   localparam int SW = tcf_pkg::STAT_W;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic wait_reg;
   logic wait_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic irq_reg;
   logic irq_next;
   logic en_reg;
   logic en_next;
   logic reload_reg;
   logic reload_next;
   logic up_reg;
   logic up_next;
   logic run_reg;
   logic run_next;
   logic done_reg;
   logic done_next;
   logic srst_reg;
   logic srst_next;
   logic [CNT_W-1:0] count_reg;
   logic [CNT_W-1:0] count_next;
   logic [CNT_W-1:0] preload_reg;
   logic [CNT_W-1:0] preload_next;
   logic [PRE_W-1:0] div_reg;
   logic [PRE_W-1:0] div_next;
   logic [SW-1:0] stat_reg;
   logic [SW-1:0] stat_next;
   logic [SW-1:0] ien_reg;
   logic [SW-1:0] ien_next;

   function automatic logic [31:0] be_merge(input logic [31:0] old_v,
      input logic [31:0] new_v, input logic [3:0] be);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            res[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return res;
   endfunction

   // ----------------------------------------------------------------
   // bus handshake
   // ----------------------------------------------------------------
   // read data latched in the first cycle; answer, and any write, in the second
   wire req = avs_read | avs_write;
   wire rd_take = avs_read & wait_reg;
   wire wr_go = avs_write & ~wait_reg;
   assign wait_next = ~(req & wait_reg);

   wire sel_ctrl = avs_address == tcf_pkg::OFF_CTRL;
   wire sel_count = avs_address == tcf_pkg::OFF_COUNT;
   wire sel_pre = avs_address == tcf_pkg::OFF_PRELOAD;
   wire sel_div = avs_address == tcf_pkg::OFF_PRESCALE;
   wire sel_stat = avs_address == tcf_pkg::OFF_STATUS;
   wire sel_clr = avs_address == tcf_pkg::OFF_INT_CLR;
   wire sel_ien = avs_address == tcf_pkg::OFF_INT_EN;

   // soft reset bit always reads zero
   logic [31:0] ctrl_rd;
   always_comb begin
      ctrl_rd = '0;
      ctrl_rd[tcf_pkg::CTRL_EN_BIT] = en_reg;
      ctrl_rd[tcf_pkg::CTRL_RELOAD_BIT] = reload_reg;
      ctrl_rd[tcf_pkg::CTRL_UP_BIT] = up_reg;
      ctrl_rd[tcf_pkg::CTRL_RUN_BIT] = run_reg;
   end

   wire [31:0] count_rd = 32'(count_reg);
   wire [31:0] pre_rd = 32'(preload_reg);
   wire [31:0] div_rd = 32'(div_reg);
   wire [31:0] stat_rd = 32'(stat_reg);
   wire [31:0] ien_rd = 32'(ien_reg);

   // clear register is write-only; unmapped reads give zero
   assign rdata_next = !rd_take ? rdata_reg :
                       sel_ctrl ? ctrl_rd :
                       sel_count ? count_rd :
                       sel_pre ? pre_rd :
                       sel_div ? div_rd :
                       sel_stat ? stat_rd :
                       sel_ien ? ien_rd : tcf_pkg::WORD_RST;

   wire [31:0] ctrl_wd = be_merge(ctrl_rd, avs_writedata, avs_byteenable);
   wire [31:0] count_wd = be_merge(count_rd, avs_writedata,
                                   avs_byteenable);
   wire [31:0] pre_wd = be_merge(pre_rd, avs_writedata, avs_byteenable);
   wire [31:0] div_wd = be_merge(div_rd, avs_writedata, avs_byteenable);
   wire [31:0] ien_wd = be_merge(ien_rd, avs_writedata, avs_byteenable);
   wire [31:0] clr_wd = be_merge(tcf_pkg::WORD_RST, avs_writedata,
                                 avs_byteenable);

   wire ctrl_wr = wr_go & sel_ctrl;
   wire cnt_wr = wr_go & sel_count;
   wire pre_wr = wr_go & sel_pre;
   wire div_wr = wr_go & sel_div;
   wire ien_wr = wr_go & sel_ien;
   wire clr_wr = wr_go & sel_clr;

   // ----------------------------------------------------------------
   // control fields
   // ----------------------------------------------------------------
   // soft reset pulse
   assign srst_next = ctrl_wr & ctrl_wd[tcf_pkg::CTRL_SRST_BIT];
   // start on a rising write of run
   wire start_w = ctrl_wr & ctrl_wd[tcf_pkg::CTRL_RUN_BIT] & ~run_reg &
                  ~srst_next;

   assign en_next = srst_reg ? tcf_pkg::CTRL_FIELD_RST :
                    ctrl_wr ? ctrl_wd[tcf_pkg::CTRL_EN_BIT] : en_reg;
   assign reload_next = srst_reg ? tcf_pkg::CTRL_FIELD_RST :
                        ctrl_wr ? ctrl_wd[tcf_pkg::CTRL_RELOAD_BIT] :
                        reload_reg;
   assign up_next = srst_reg ? tcf_pkg::CTRL_FIELD_RST :
                    ctrl_wr ? ctrl_wd[tcf_pkg::CTRL_UP_BIT] : up_reg;

   // ----------------------------------------------------------------
   // divider and counter
   // ----------------------------------------------------------------
   logic pre_tick;
   // divider runs only while run is set
   wire pre_run = run_reg & en_reg;
   wire pre_clr = start_w | srst_reg;

   tcf_prescale #(
      .PRE_W(PRE_W)
   ) u_prescale (
      .clk(clk),
      .nrst(nrst),
      .clr(pre_clr),
      .run(pre_run),
      .div(div_reg),
      .tick(pre_tick)
   );

   // divider tick is one cycle late, so it is gated again here
   wire tick_ok = pre_tick & run_reg & en_reg & ~srst_reg;
   wire [CNT_W-1:0] cnt_step = up_reg ? count_reg + 1'b1 :
                               count_reg - 1'b1;
   // all ones is the end going up
   wire up_end = &count_reg;
   wire up_reach = &cnt_step;
   // zero is the end going down
   wire dn_end = count_reg == '0;
   wire dn_reach = cnt_step == '0;
   wire at_end = up_reg ? up_end : dn_end;
   wire reach = up_reg ? up_reach : dn_reach;
   wire term = tick_ok & (at_end | reach);
   wire term_rl = term & reload_reg;
   wire term_dn = term & ~reload_reg;

   // saturate: never step past the end value
   assign count_next = srst_reg ? '0 :
                       cnt_wr ? count_wd[CNT_W-1:0] :
                       term_rl ? preload_reg :
                       (tick_ok & ~at_end) ? cnt_step : count_reg;
   assign preload_next = srst_reg ? '0 :
                         pre_wr ? pre_wd[CNT_W-1:0] : preload_reg;
   assign div_next = srst_reg ? '0 :
                     div_wr ? div_wd[PRE_W-1:0] : div_reg;

   // clearing run halts; done mode clears run itself
   assign run_next = srst_reg ? 1'b0 :
                     ctrl_wr ? ctrl_wd[tcf_pkg::CTRL_RUN_BIT] :
                     term_dn ? 1'b0 : run_reg;
   // done state held until the next start or soft reset
   assign done_next = (srst_reg | start_w) ? 1'b0 :
                      term_dn ? 1'b1 : done_reg;

   // ----------------------------------------------------------------
   // interrupt status
   // ----------------------------------------------------------------
   logic [SW-1:0] stat_set;
   always_comb begin
      stat_set = '0;
      stat_set[tcf_pkg::STAT_TERM_BIT] = term;
      // done bit reasserts every cycle as a level
      stat_set[tcf_pkg::STAT_DONE_BIT] = term_dn | done_reg;
   end
   wire [SW-1:0] stat_clr = clr_wr ? clr_wd[SW-1:0] : '0;
   // start wipes pending events; otherwise set wins over clear
   assign stat_next = (srst_reg | start_w) ? tcf_pkg::STAT_RST :
                      (stat_reg & ~stat_clr) | stat_set;
   assign ien_next = srst_reg ? tcf_pkg::STAT_RST :
                     ien_wr ? ien_wd[SW-1:0] : ien_reg;
   assign irq_next = |(stat_next & ien_next);

   assign avs_readdata = rdata_reg;
   assign avs_waitrequest = wait_reg;
   assign irq = irq_reg;

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!nrst) begin
         wait_reg <= 1'b1;
         rdata_reg <= tcf_pkg::WORD_RST;
         irq_reg <= 1'b0;
         srst_reg <= 1'b0;
      end else begin
         wait_reg <= wait_next;
         rdata_reg <= rdata_next;
         irq_reg <= irq_next;
         srst_reg <= srst_next;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         en_reg <= tcf_pkg::CTRL_FIELD_RST;
         reload_reg <= tcf_pkg::CTRL_FIELD_RST;
         up_reg <= tcf_pkg::CTRL_FIELD_RST;
         run_reg <= tcf_pkg::CTRL_FIELD_RST;
         done_reg <= 1'b0;
      end else begin
         en_reg <= en_next;
         reload_reg <= reload_next;
         up_reg <= up_next;
         run_reg <= run_next;
         done_reg <= done_next;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         count_reg <= '0;
         preload_reg <= '0;
         div_reg <= '0;
         stat_reg <= tcf_pkg::STAT_RST;
         ien_reg <= tcf_pkg::STAT_RST;
      end else begin
         count_reg <= count_next;
         preload_reg <= preload_next;
         div_reg <= div_next;
         stat_reg <= stat_next;
         ien_reg <= ien_next;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   sequence s_start;
      start_w;
   endsequence

   sequence s_fresh_run;
      run_reg && stat_reg == '0 && !done_reg;
   endsequence

   halt_hold_a: assert property (@(posedge clk) disable iff (!nrst)
      (!run_reg && !cnt_wr && !srst_reg) |=> $stable(count_reg))
      else $error("count moved while halted");

   // soft reset pulse lasts one cycle
   srst_pulse_a: assert property (@(posedge clk) disable iff (!nrst)
      srst_reg |=> !srst_reg)
      else $error("soft reset did not self clear");

   srst_init_a: assert property (@(posedge clk) disable iff (!nrst)
      srst_reg |=> (count_reg == '0 && !run_reg && !en_reg &&
                    stat_reg == '0 && ctrl_rd[tcf_pkg::CTRL_SRST_BIT] == 0))
      else $error("soft reset left state behind");

   reload_go_a: assert property (@(posedge clk) disable iff (!nrst)
      (term_rl && !cnt_wr && !ctrl_wr) |=>
      (count_reg == $past(preload_reg) && run_reg &&
       stat_reg[tcf_pkg::STAT_TERM_BIT]))
      else $error("reload on terminal failed");

   // done mode stops and holds the level
   done_stop_a: assert property (@(posedge clk) disable iff (!nrst)
      (term_dn && !ctrl_wr) |=> (!run_reg && done_reg &&
      stat_reg[tcf_pkg::STAT_DONE_BIT]))
      else $error("done state not entered");

   // done level cannot be cleared away
   done_level_a: assert property (@(posedge clk) disable iff (!nrst)
      (done_reg && !start_w && !srst_reg) |=>
      stat_reg[tcf_pkg::STAT_DONE_BIT])
      else $error("done level dropped");

   up_sat_a: assert property (@(posedge clk) disable iff (!nrst)
      (tick_ok && up_reg && up_end && !reload_reg && !cnt_wr) |=>
      (&count_reg && stat_reg[tcf_pkg::STAT_TERM_BIT]))
      else $error("up count passed all ones");

   // downward step of one while short of zero
   down_step_a: assert property (@(posedge clk) disable iff (!nrst)
      (tick_ok && !up_reg && !dn_end && !dn_reach && !cnt_wr) |=>
      count_reg == $past(count_reg) - 1'b1)
      else $error("down count step wrong");

   start_clean_a: assert property (@(posedge clk) disable iff (!nrst)
      s_start |=> s_fresh_run)
      else $error("start did not clear events");

   gate_off_a: assert property (@(posedge clk) disable iff (!nrst)
      (!en_reg && !cnt_wr && !srst_reg) |=>
      ($stable(count_reg) && !term))
      else $error("counted while disabled");

   mode_reset_a: assert property (@(posedge clk)
      !nrst |=> (!reload_reg && !up_reg && !en_reg))
      else $error("mode fields not zero after reset");

endmodule

//--- hdl/tcf_pkg.sv
// constants shared by the timer control block
package tcf_pkg;

   // ----------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------
   localparam logic [4:0] OFF_CTRL = 5'h00;
   localparam logic [4:0] OFF_COUNT = 5'h04;
   localparam logic [4:0] OFF_PRELOAD = 5'h08;
   localparam logic [4:0] OFF_PRESCALE = 5'h0C;
   localparam logic [4:0] OFF_STATUS = 5'h10;
   localparam logic [4:0] OFF_INT_CLR = 5'h14;
   localparam logic [4:0] OFF_INT_EN = 5'h18;

   // ----------------------------------------------------------------
   // control field positions
   // ----------------------------------------------------------------
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_RELOAD_BIT = 1;
   localparam int CTRL_UP_BIT = 2;
   localparam int CTRL_SRST_BIT = 3;
   localparam int CTRL_RUN_BIT = 5;

   // ----------------------------------------------------------------
   // status, clear and enable layout
   // ----------------------------------------------------------------
   localparam int STAT_W = 2;
   localparam int STAT_TERM_BIT = 0;
   localparam int STAT_DONE_BIT = 1;

   // ----------------------------------------------------------------
   // values after reset
   // ----------------------------------------------------------------
   localparam logic CTRL_FIELD_RST = 1'b0;
   localparam logic [STAT_W-1:0] STAT_RST = 2'h0;
   localparam logic [31:0] WORD_RST = 32'h0000_0000;

   // ----------------------------------------------------------------
   // cycle counts
   // ----------------------------------------------------------------
   localparam int SRST_CYCLES = 1;

endpackage

//--- hdl/tcf_prescale.sv
// clock divider that paces the timer counter
`timescale 1ns/1ps

module tcf_prescale #(
   parameter int PRE_W = 16
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic clr,
   input wire logic run,
   input wire logic [PRE_W-1:0] div,
   output logic tick
);

   logic [PRE_W-1:0] cnt_reg;
   logic [PRE_W-1:0] cnt_next;
   logic tick_reg;
   logic tick_next;
   logic wrap;

   // ----------------------------------------------------------------
   // divider: one tick every div+1 cycles while running
   // ----------------------------------------------------------------
   // >= so that shrinking div mid-count cannot run past it
   assign wrap = cnt_reg >= div;
   assign cnt_next = clr ? '0 : (!run ? cnt_reg :
                     (wrap ? '0 : cnt_reg + 1'b1));
   assign tick_next = ~clr & run & wrap;
   assign tick = tick_reg;

   always_ff @(posedge clk) begin
      if (!nrst) begin
         cnt_reg <= '0;
         tick_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         tick_reg <= tick_next;
      end
   end

endmodule

//--- test/tcf_timer_bench.sv
// self-checking bench for the timer control block
`timescale 1ns/1ps
module tcf_timer_bench;
   logic clk;
   logic nrst;
   logic [4:0] avs_address;
   logic avs_read;
   logic avs_write;
   logic [31:0] avs_writedata;
   logic [3:0] avs_byteenable;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic irq;
   logic [31:0] rd;
   logic [31:0] v;
   logic [32:0] e;
   logic [32:0] exp_q[$];
   int n_fail;
   int compares;
   int cyc;
   integer seed;

   tcf_timer #(.CNT_W(32), .PRE_W(16)) u_dut (
      .clk(clk),
      .nrst(nrst),
      .avs_address(avs_address),
      .avs_read(avs_read),
      .avs_write(avs_write),
      .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest),
      .irq(irq)
   );

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // ----------------------------------------------------------------
   // reporting and comparison
   // ----------------------------------------------------------------
   task automatic fail_msg(input string m);
      n_fail++;
      $display("[FAIL] %0t %s", $time, m);
   endtask

   task automatic cmp_data(input logic [31:0] got, input logic [31:0] x);
      compares++;
      if (got !== x)
         fail_msg($sformatf("read %h expected %h", got, x));
   endtask

   // irq comes from a register, so let the write settle first
   task automatic cmp_irq(input logic x);
      repeat (2) @(posedge clk);
      @(negedge clk);
      compares++;
      if (irq !== x)
         fail_msg("irq level wrong");
   endtask

   task automatic complete_run;
      $display("counts: compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // bus master
   // ----------------------------------------------------------------
   // waitrequest read at the rising edge, before the design's registers
   // update, so it is the value the slave itself sampled there
   task automatic bus(input logic w, input logic [4:0] a,
                      input logic [31:0] d, input logic [3:0] be);
      @(posedge clk);
      avs_read <= !w;
      avs_write <= w;
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask

   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 4'hF);
   endtask

   task automatic rd_chk(input logic [4:0] a, input logic [31:0] x);
      exp_q.push_back({1'b1, x});
      bus(1'b0, a, 32'h0, 4'hF);
   endtask

   task automatic rd_raw(input logic [4:0] a);
      exp_q.push_back({1'b0, 32'h0});
      bus(1'b0, a, 32'h0, 4'hF);
   endtask

   task automatic wait_stat(input int b);
      int i;
      i = 0;
      do begin
         rd_raw(tcf_pkg::OFF_STATUS);
         i++;
      end while (rd[b] !== 1'b1 && i < 100);
      if (rd[b] !== 1'b1)
         fail_msg("terminal event never seen");
   endtask

   // ----------------------------------------------------------------
   // monitor and timeout
   // ----------------------------------------------------------------
   always @(negedge clk) begin
      if (nrst && avs_read && avs_waitrequest === 1'b0) begin
         if (exp_q.size() == 0) begin
            fail_msg("read without a note");
         end else begin
            e = exp_q.pop_front();
            if (e[32])
               cmp_data(avs_readdata, e[31:0]);
         end
      end
   end

   // whole run needs a few hundred cycles
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fail_msg("timeout");
         complete_run();
      end
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      seed = 32'h1709f3c4;
      nrst = 1'b0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 5'h00;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hF;
      n_fail = 0;
      compares = 0;
      cyc = 0;
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      rd_chk(tcf_pkg::OFF_CTRL, 32'h0);
      rd_chk(tcf_pkg::OFF_STATUS, 32'h0);
      wr(5'h1C, 32'hFFFFFFFF);
      rd_chk(5'h1C, 32'h0);
      cmp_irq(1'b0);
      $display("test reset values done");
      // run without enable must not count
      wr(tcf_pkg::OFF_COUNT, 32'h5);
      wr(tcf_pkg::OFF_CTRL, 32'h20);
      repeat (20) @(posedge clk);
      rd_chk(tcf_pkg::OFF_COUNT, 32'h5);
      wr(tcf_pkg::OFF_CTRL, 32'h0);
      $display("test enable gate done");
      wr(tcf_pkg::OFF_INT_EN, 32'h3);
      wr(tcf_pkg::OFF_COUNT, 32'h3);
      wr(tcf_pkg::OFF_CTRL, 32'h21);
      wait_stat(1);
      repeat (5) @(posedge clk);
      rd_chk(tcf_pkg::OFF_COUNT, 32'h0);
      rd_chk(tcf_pkg::OFF_CTRL, 32'h1);
      rd_chk(tcf_pkg::OFF_STATUS, 32'h3);
      wr(tcf_pkg::OFF_INT_CLR, 32'h3);
      rd_chk(tcf_pkg::OFF_STATUS, 32'h2);
      cmp_irq(1'b1);
      wr(tcf_pkg::OFF_INT_EN, 32'h0);
      cmp_irq(1'b0);
      $display("test done mode done");
      wr(tcf_pkg::OFF_PRESCALE, 32'h1);
      wr(tcf_pkg::OFF_COUNT, 32'd1000);
      wr(tcf_pkg::OFF_CTRL, 32'h21);
      rd_chk(tcf_pkg::OFF_STATUS, 32'h0);
      repeat (10) @(posedge clk);
      wr(tcf_pkg::OFF_CTRL, 32'h1);
      rd_raw(tcf_pkg::OFF_COUNT);
      v = rd;
      cmp_data(32'(v < 32'd1000), 32'h1);
      repeat (20) @(posedge clk);
      rd_chk(tcf_pkg::OFF_COUNT, v);
      $display("test halt done");
      wr(tcf_pkg::OFF_PRESCALE, 32'h0);
      wr(tcf_pkg::OFF_PRELOAD, 32'h4);
      wr(tcf_pkg::OFF_COUNT, 32'h2);
      wr(tcf_pkg::OFF_INT_EN, 32'h1);
      wr(tcf_pkg::OFF_CTRL, 32'h23);
      wait_stat(0);
      rd_chk(tcf_pkg::OFF_CTRL, 32'h23);
      rd_chk(tcf_pkg::OFF_STATUS, 32'h1);
      rd_raw(tcf_pkg::OFF_COUNT);
      cmp_data(32'(rd != 32'h0 && rd <= 32'h4), 32'h1);
      cmp_irq(1'b1);
      wr(tcf_pkg::OFF_CTRL, 32'h1);
      $display("test reload mode done");
      wr(tcf_pkg::OFF_COUNT, 32'hFFFFFFFD);
      wr(tcf_pkg::OFF_CTRL, 32'h25);
      wait_stat(1);
      rd_chk(tcf_pkg::OFF_COUNT, 32'hFFFFFFFF);
      rd_chk(tcf_pkg::OFF_STATUS, 32'h3);
      // restart while already at all ones: must stay saturated
      wr(tcf_pkg::OFF_CTRL, 32'h25);
      wait_stat(1);
      rd_chk(tcf_pkg::OFF_COUNT, 32'hFFFFFFFF);
      $display("test count up done");
      repeat (3) begin
         v = $random(seed);
         wr(tcf_pkg::OFF_PRELOAD, v);
         rd_chk(tcf_pkg::OFF_PRELOAD, v);
      end
      wr(tcf_pkg::OFF_COUNT, 32'h11223344);
      bus(1'b1, tcf_pkg::OFF_COUNT, 32'hAABBCCDD, 4'h1);
      rd_chk(tcf_pkg::OFF_COUNT, 32'h112233DD);
      $display("test data paths done");
      wr(tcf_pkg::OFF_INT_EN, 32'h3);
      wr(tcf_pkg::OFF_CTRL, 32'h0F);
      repeat (2) @(posedge clk);
      rd_chk(tcf_pkg::OFF_CTRL, 32'h0);
      rd_chk(tcf_pkg::OFF_COUNT, 32'h0);
      rd_chk(tcf_pkg::OFF_INT_EN, 32'h0);
      rd_chk(tcf_pkg::OFF_PRELOAD, 32'h0);
      cmp_irq(1'b0);
      $display("test soft reset done");
      complete_run();
   end
endmodule
